// ---- core/vic_pkg.sv ----
// Shared constants and types of the vectored interrupt controller.
// Assumes a 32-bit Avalon-MM register bus and a core that acknowledges vectors.
package vic_pkg;
	// Register byte addresses on the Avalon-MM bus.
	localparam logic [3:0] REQ_FLAGS_ADDR = 4'h0;
	localparam logic [3:0] MASK_FLAGS_ADDR = 4'h4;
	localparam logic [3:0] CONTROL_ADDR = 4'h8;
	localparam logic [3:0] PSW_ADDR = 4'hC;
	// Reset values.
	localparam logic [7:0] REQ_FLAGS_RST = 8'h00;
	localparam logic [7:0] MASK_FLAGS_RST = 8'hFF;
	localparam logic [7:0] PSW_RST = 8'h02;
	localparam logic [4:0] CONTROL_RST = 5'h00;
	// Field positions.
	localparam int PSW_IE_BIT = 7;
	localparam int CTL_WDT_MODE_BIT = 0;
	localparam int CTL_KEY_EN_BIT = 1;
	localparam int CTL_EDGE_LO_BIT = 2;
	localparam int CTL_EDGE_HI_BIT = 3;
	localparam int CTL_SERIAL_BIT = 4;
	// Request flag positions, index equals priority.
	localparam int SRC_WDT = 0;
	localparam int SRC_PIN = 1;
	localparam int SRC_SERIAL = 2;
	localparam int SRC_WATCH = 3;
	localparam int SRC_TIMER_A = 4;
	localparam int SRC_TIMER_B = 5;
	localparam int SRC_KEY = 6;
	localparam int SRC_INTERVAL = 7;
	// Vector table: base plus two bytes per priority level.
	localparam logic [15:0] NMI_VECTOR = 16'h0004;
	localparam logic [15:0] MASKABLE_VECTOR_BASE = 16'h0004;
	localparam logic [15:0] VECTOR_STEP = 16'h0002;
	// Edge select codes.
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Request presented to the core.
	typedef struct packed {
		logic valid;
		logic nmi;
		logic [15:0] vector;
	} vic_request_s;

	// One-cycle event pulses from the on-chip sources.
	typedef struct packed {
		logic watchdogOverflow;
		logic serialRxDone;
		logic watchTick;
		logic timerAMatch;
		logic timerBMatch;
		logic watchInterval;
	} vic_events_s;
endpackage : vic_pkg

// ---- core/vic_controller.sv ----
// Vectored interrupt controller: one non-maskable and eight maskable sources.
// Software clears a flag by writing one to its bit; an event in the same
// cycle keeps it set, so no request is lost to a late clear.
// Assumes a core that pulses coreAck once per presented request, and
// peripheral event pulses that are synchronous to clock.
// The edge pin and key lines may be asynchronous to clock.
//
// How it works
// - Non-maskable request ignores masks, enable, arbitration.
// - Watchdog overflow in watchdog mode vectors 0004H.
// - Any generated request pulses standby release.
// - Unmasked requests arbitrated, priority 0 highest.
// - Interval-mode watchdog overflow is priority 0.
// - Selected pin edge raises priority 1, 0006H.
// - Serial receive end raises priority 2, 0008H.
// - Watch, timer A, timer B at 3-5.
// - Key return detection raises priority 6, 0010H.
// - Watch interval raises priority 7, 0012H.
// - Eight sources, seven without serial variant.
// - Acknowledge clears flag; flags reset to zero.
// - Masks reset to all ones; masked at load time never presented.
// - Acknowledge pushes status word, clears global enable.
// - Edge select 00 fall, 01 rise, 11 both.
module vic_controller #(
	parameter bit HAS_SERIAL = 1'b1
) (
	input wire logic clock,
	input wire logic arst_n,
	// Avalon-MM slave.
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// On-chip sources and pins.
	input wire vic_pkg::vic_events_s events,
	input wire logic extPin,
	input wire logic [3:0] keyPins,
	// Core side.
	output vic_pkg::vic_request_s coreRequest,
	input wire logic coreAck,
	output logic [7:0] pushedPsw,
	output logic pushStrobe,
	output logic standbyRelease,
	output logic irq
);
	logic [7:0] reqFlags_r;
	logic [7:0] reqFlags_nxt;
	logic [7:0] maskFlags_r;
	logic [7:0] psw_r;
	logic [7:0] psw_nxt;
	logic [4:0] control_r;
	// Pending non-maskable request, kept apart from the maskable flags.
	logic nmiPend_r;
	logic nmiPend_nxt;
	logic [1:0] pinSync_r;
	logic pinPrev_r;
	logic keyPrev_r;
	logic [3:0] keyMeta_r;
	logic [3:0] keySync_r;
	logic busAck_r;
	logic [31:0] readdata_r;
	// Request as it is held for the core.
	logic presValid_r;
	logic presNmi_r;
	logic [2:0] presSel_r;
	logic [7:0] pushedPsw_r;
	logic pushStrobe_r;
	logic standby_r;

	// Edge detection on synchronised pins.
	// Code 10 of the edge select is prohibited and detects nothing.
	wire logic [1:0] edgeSelect = control_r[vic_pkg::CTL_EDGE_HI_BIT:vic_pkg::CTL_EDGE_LO_BIT];
	wire logic pinNow = pinSync_r[1];
	wire logic pinRise = pinNow & ~pinPrev_r;
	wire logic pinFall = ~pinNow & pinPrev_r;
	wire logic pinEdge = (edgeSelect == vic_pkg::EDGE_FALL) ? pinFall :
		(edgeSelect == vic_pkg::EDGE_RISE) ? pinRise :
		(edgeSelect == vic_pkg::EDGE_BOTH) ? (pinRise | pinFall) : 1'b0;
	// A key return is seen only when all four lines were high and one falls.
	// Lines already low when detection is enabled cannot raise a false return.
	wire logic keyAllHigh = &keySync_r;
	wire logic keyEdge = control_r[vic_pkg::CTL_KEY_EN_BIT] & keyPrev_r & ~keyAllHigh;
	wire logic wdtNmiMode = control_r[vic_pkg::CTL_WDT_MODE_BIT];
	wire logic serialOn = HAS_SERIAL & control_r[vic_pkg::CTL_SERIAL_BIT];

	// Source events gathered into one vector, index equals priority.
	wire logic [7:0] srcEvents = {
		events.watchInterval,
		keyEdge,
		events.timerBMatch,
		events.timerAMatch,
		events.watchTick,
		events.serialRxDone & serialOn,
		pinEdge,
		events.watchdogOverflow & ~wdtNmiMode
	};
	wire logic nmiEvent = events.watchdogOverflow & wdtNmiMode;

	// Bus decode; accesses complete after one wait state.
	// waitrequest stays high while idle, so a master must wait for it to drop.
	// Only byte lane 0 carries register bits; the upper lanes read as zero.
	wire logic busReq = read | write;
	wire logic busDone = busReq & busAck_r;
	wire logic wrDone = write & busAck_r;
	wire logic selReq = (address == vic_pkg::REQ_FLAGS_ADDR);
	wire logic selMask = (address == vic_pkg::MASK_FLAGS_ADDR);
	wire logic selCtl = (address == vic_pkg::CONTROL_ADDR);
	wire logic selPsw = (address == vic_pkg::PSW_ADDR);
	wire logic wrLane0 = wrDone & byteenable[0];
	wire logic [31:0] readMux = selReq ? {24'h000000, reqFlags_r} :
		selMask ? {24'h000000, maskFlags_r} :
		selCtl ? {27'h0000000, control_r} :
		selPsw ? {24'h000000, psw_r} : 32'h00000000;

	// Arbitration picks the lowest index among unmasked pending flags.
	// Scanning from the lowest priority upward lets the highest one win last.
	wire logic [7:0] unmasked = reqFlags_r & ~maskFlags_r;
	wire logic globalEnable = psw_r[vic_pkg::PSW_IE_BIT];
	logic [2:0] winSel;
	always_comb
	begin
		winSel = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (unmasked[i])
			begin
				winSel = i[2:0];
			end
		end
	end
	wire logic anyUnmasked = |unmasked;
	// The non-maskable request is loaded only when nothing is presented, so a
	// maskable request already on offer is finished first; this keeps the
	// vector stable for the core at the cost of one service of latency.
	wire logic loadNmi = ~presValid_r & nmiPend_r;
	wire logic loadMask = ~presValid_r & ~nmiPend_r & globalEnable & anyUnmasked;
	wire logic ackTaken = presValid_r & coreAck;
	wire logic [7:0] ackClear = (ackTaken & ~presNmi_r) ? (8'h01 << presSel_r) : 8'h00;
	// Vector of a maskable level: two bytes per entry above the table base.
	wire logic [15:0] selVector = vic_pkg::MASKABLE_VECTOR_BASE +
		(vic_pkg::VECTOR_STEP * {13'h0000, presSel_r});

	// Request flags: a new event wins over software and acknowledge clears.
	// Without the serial unit its flag is forced low whatever software writes.
	always_comb
	begin
		reqFlags_nxt = reqFlags_r;
		if (wrLane0 && selReq)
		begin
			reqFlags_nxt = reqFlags_nxt & ~writedata[7:0];
		end
		reqFlags_nxt = reqFlags_nxt & ~ackClear;
		reqFlags_nxt = reqFlags_nxt | srcEvents;
		if (!HAS_SERIAL)
		begin
			reqFlags_nxt[vic_pkg::SRC_SERIAL] = 1'b0;
		end
	end

	// The non-maskable flag is dropped only by its own acknowledge.
	always_comb
	begin
		nmiPend_nxt = nmiPend_r;
		if (ackTaken && presNmi_r)
		begin
			nmiPend_nxt = 1'b0;
		end
		if (nmiEvent)
		begin
			nmiPend_nxt = 1'b1;
		end
	end

	// Status word: software writes it; any acknowledge drops the enable.
	// The acknowledge wins over a software write in the same cycle, so the
	// service routine always starts with maskable requests disabled.
	always_comb
	begin
		psw_nxt = psw_r;
		if (wrLane0 && selPsw)
		begin
			psw_nxt = writedata[7:0];
		end
		if (ackTaken)
		begin
			psw_nxt[vic_pkg::PSW_IE_BIT] = 1'b0;
		end
	end

	// Two-stage synchronisers for the pin inputs.
	// Only the second stage is read by logic; the first may go metastable.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinSync_r <= 2'h0;
			keyMeta_r <= 4'h0;
			keySync_r <= 4'h0;
		end
		else
		begin
			pinSync_r <= {pinSync_r[0], extPin};
			keyMeta_r <= keyPins;
			keySync_r <= keyMeta_r;
		end
	end

	// Previous levels for the edge detectors.
	// Reset values match the synchroniser resets so that release causes no false event.
	// The key detector starts from not-all-high, so lines that settle high
	// after reset are never mistaken for a return.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinPrev_r <= 1'b0;
			keyPrev_r <= 1'b0;
		end
		else
		begin
			pinPrev_r <= pinNow;
			keyPrev_r <= keyAllHigh;
		end
	end

	// Software-visible registers.
	// Mask and control writes take effect at the edge that completes the access.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reqFlags_r <= vic_pkg::REQ_FLAGS_RST;
			maskFlags_r <= vic_pkg::MASK_FLAGS_RST;
			control_r <= vic_pkg::CONTROL_RST;
			psw_r <= vic_pkg::PSW_RST;
			nmiPend_r <= 1'b0;
		end
		else
		begin
			reqFlags_r <= reqFlags_nxt;
			psw_r <= psw_nxt;
			nmiPend_r <= nmiPend_nxt;
			if (wrLane0 && selMask)
			begin
				maskFlags_r <= writedata[7:0];
			end
			if (wrLane0 && selCtl)
			begin
				control_r <= writedata[4:0];
			end
		end
	end

	// Bus handshake: read data is captured in the wait cycle.
	// Capturing early keeps readdata steady at the completing edge.
	// Every access takes exactly one wait state, reads and writes alike.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busAck_r <= 1'b0;
			readdata_r <= 32'h00000000;
		end
		else
		begin
			busAck_r <= busReq & ~busAck_r;
			if (read && !busAck_r)
			begin
				readdata_r <= readMux;
			end
		end
	end

	// Presented request; held steady until the core takes it.
	// Masks changed after loading do not withdraw the offer; the core must
	// still acknowledge it once.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			presValid_r <= 1'b0;
			presNmi_r <= 1'b0;
			presSel_r <= 3'h0;
		end
		else if (loadNmi)
		begin
			presValid_r <= 1'b1;
			presNmi_r <= 1'b1;
			presSel_r <= 3'h0;
		end
		else if (loadMask)
		begin
			presValid_r <= 1'b1;
			presNmi_r <= 1'b0;
			presSel_r <= winSel;
		end
		else if (ackTaken)
		begin
			presValid_r <= 1'b0;
		end
	end

	// Stack push and standby release pulses.
	// Standby release follows every generated request, masked or not.
	// The pushed word keeps the enable as it was before the acknowledge.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pushedPsw_r <= 8'h00;
			pushStrobe_r <= 1'b0;
			standby_r <= 1'b0;
		end
		else
		begin
			pushStrobe_r <= ackTaken;
			if (ackTaken)
			begin
				pushedPsw_r <= psw_r;
			end
			standby_r <= nmiEvent | (|srcEvents);
		end
	end

	// Outputs.
	// The vector comes from held registers, so it is stable while valid is.
	assign readdata = readdata_r;
	assign waitrequest = ~busAck_r;
	assign coreRequest.valid = presValid_r;
	assign coreRequest.nmi = presNmi_r;
	assign coreRequest.vector = presNmi_r ? vic_pkg::NMI_VECTOR : selVector;
	assign pushedPsw = pushedPsw_r;
	assign pushStrobe = pushStrobe_r;
	assign standbyRelease = standby_r;
	// Level interrupt: unmasked pending flag or a pending non-maskable one.
	// It stays high while a request waits, even with the global enable clear.
	assign irq = anyUnmasked | nmiPend_r;
endmodule : vic_controller

// ---- sim/vic_monitor.sv ----
// Port checker of the vectored interrupt controller.
// Assumes the vic_controller ports; bound to every instance below.
module vic_monitor (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire vic_pkg::vic_events_s events,
	input wire vic_pkg::vic_request_s coreRequest,
	input wire logic coreAck,
	input wire logic pushStrobe,
	input wire logic standbyRelease
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Vectors stay inside the table, so a stray index cannot reach the core.
	chk_nmi_vector: assert property (coreRequest.valid && coreRequest.nmi |->
		coreRequest.vector == 16'h0004) else $error("nmi vector wrong");
	chk_vector_table: assert property (coreRequest.valid |-> !coreRequest.vector[0] &&
		coreRequest.vector inside {[16'h0004:16'h0012]}) else $error("vector off table");
	chk_request_hold: assert property (coreRequest.valid && !coreAck |=>
		coreRequest.valid && $stable(coreRequest.vector)) else $error("request dropped");
	chk_ack_clears: assert property (coreRequest.valid && coreAck |=> !coreRequest.valid)
		else $error("request kept after ack");
	chk_status_push: assert property (coreRequest.valid && coreAck |=>
		pushStrobe ##1 !pushStrobe) else $error("push pulse wrong");
	chk_push_cause: assert property (pushStrobe |-> $past(coreAck && coreRequest.valid))
		else $error("push without ack");
	chk_standby_wake: assert property (|events |=> standbyRelease)
		else $error("no standby release");
	chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus wait not one cycle");
endmodule : vic_monitor

bind vic_controller vic_monitor u_mon (.clock, .arst_n, .read, .write, .waitrequest, .events,
	.coreRequest, .coreAck, .pushStrobe, .standbyRelease);

// ---- sim/vic_core_model.sv ----
// Processor core model: takes presented vectors after a chosen wait.
// Assumes coreRequest holds until acknowledged.
module vic_core_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire vic_pkg::vic_request_s coreRequest,
	input wire logic [3:0] ackDelay,
	output logic coreAck,
	output logic [15:0] lastVector,
	output logic lastNmi,
	output logic [7:0] ackCount
);
	logic [3:0] waitCnt_r;
	// A zero delay answers at once; a long one shows the request is held.
	assign coreAck = coreRequest.valid && waitCnt_r == ackDelay;
	// Count waiting cycles and log each vector taken.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			waitCnt_r <= 4'h0;
			ackCount <= 8'h00;
			lastVector <= 16'h0000;
			lastNmi <= 1'b0;
		end
		else if (coreAck)
		begin
			waitCnt_r <= 4'h0;
			ackCount <= ackCount + 8'h01;
			lastVector <= coreRequest.vector;
			lastNmi <= coreRequest.nmi;
		end
		else if (coreRequest.valid)
			waitCnt_r <= waitCnt_r + 4'h1;
	end
endmodule : vic_core_model

// ---- sim/vic_controller_test.sv ----
// Self-checking bench of the vectored interrupt controller.
// Assumes the core model answers vectors; the bench drives bus and sources.
module vic_controller_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, arst_n, read, write, extPin, coreAck, waitrequest, lastNmi;
	logic pushStrobe, standbyRelease, irq;
	logic [3:0] address, keyPins, ackDelay;
	logic [31:0] writedata, readdata;
	logic [7:0] pushedPsw, ackCount, q;
	logic [15:0] lastVector;
	vic_pkg::vic_events_s events;
	vic_pkg::vic_request_s coreRequest;
	int nTests, miscompares, k;
	// A 250 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	vic_controller u_dut (.clock, .arst_n, .address, .read, .write, .writedata,
		.byteenable(4'hF), .readdata, .waitrequest, .events, .extPin, .keyPins,
		.coreRequest, .coreAck, .pushedPsw, .pushStrobe, .standbyRelease, .irq);
	vic_core_model u_core (.clock, .arst_n, .coreRequest, .ackDelay, .coreAck,
		.lastVector, .lastNmi, .ackCount);
	task conclude(input logic timedOut);
		miscompares += timedOut;
		$display("tests %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task check(input logic [15:0] seen, input logic [15:0] want);
		nTests++;
		if (seen !== want)
		begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check
	// One transfer, held until waitrequest is seen low at an edge.
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int i;
		@(posedge clock);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, d};
		for (i = 0; i < 20; i++)
		begin
			@(posedge clock);
			if (waitrequest === 1'b0)
				break;
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		if (i == 20)
			conclude(1'b1);
	endtask : bus
	task rd(input logic [3:0] a, input logic [7:0] want);
		bus(1'b0, a, 8'h00);
		check({8'h00, q}, {8'h00, want});
	endtask : rd
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task pulse(input logic [5:0] e);
		@(posedge clock);
		events <= e;
		@(posedge clock);
		events <= 6'h00;
	endtask : pulse
	// Wait for the next acknowledge; the top bit of want is the nmi flag.
	task serve(input logic [15:0] want);
		logic [7:0] n;
		int i;
		n = ackCount + 8'h01;
		for (i = 0; i < 40 && ackCount !== n; i++)
			@(posedge clock);
		if (i == 40)
			conclude(1'b1);
		else
			check({lastNmi, lastVector[14:0]}, want);
	endtask : serve
	// Reset values, an unmapped hole and a masked source.
	task t_reset;
		rd(4'h0, 8'h00);
		rd(4'h4, 8'hFF);
		rd(4'hC, 8'h02);
		rd(4'h2, 8'h00);
		wr(4'hC, 8'h82);
		pulse(6'h02);
		repeat (5) @(posedge clock);
		check({15'h0, coreRequest.valid}, 16'h0000);
		check({15'h0, irq}, 16'h0000);
		rd(4'h0, 8'h20);
		wr(4'h0, 8'hFF);
	endtask : t_reset
	// All six on-chip event sources at once drain in priority order; pin and key stay idle.
	task t_order;
		logic [15:0] vec [6] = '{16'h0004, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0012};
		wr(4'hC, 8'h00);
		wr(4'h8, 8'h10);
		wr(4'h4, 8'h00);
		pulse(6'h3F);
		rd(4'h0, 8'hBD);
		check({15'h0, irq}, 16'h0001);
		for (k = 0; k < 6; k++)
		begin
			wr(4'hC, 8'h82);
			serve(vec[k]);
			check({8'h00, pushedPsw}, 16'h0082);
		end
		rd(4'hC, 8'h02);
		check({15'h0, irq}, 16'h0000);
	endtask : t_order
	task edgeChk(input logic lvl, input logic hit);
		@(posedge clock);
		extPin <= lvl;
		repeat (6) @(posedge clock);
		rd(4'h0, {6'h00, hit, 1'b0});
		wr(4'h0, 8'hFF);
	endtask : edgeChk
	// Every legal edge code against both pin edges.
	task t_pin;
		logic [1:0] code;
		wr(4'h4, 8'hFD);
		for (k = 0; k < 3; k++)
		begin
			code = (k == 2) ? 2'h3 : k[1:0];
			wr(4'h8, {4'h1, code, 2'h0});
			edgeChk(1'b1, code != 2'h0);
			edgeChk(1'b0, code != 2'h1);
		end
		@(posedge clock);
		extPin <= 1'b1;
		wr(4'hC, 8'h82);
		serve(16'h0006);
	endtask : t_pin
	task t_key;
		wr(4'h8, 8'h02);
		wr(4'h4, 8'hBF);
		@(posedge clock);
		keyPins <= 4'hB;
		wr(4'hC, 8'h82);
		serve(16'h0010);
	endtask : t_key
	// Watchdog in its non-maskable form only, beating a pending timer.
	task t_nmi;
		ackDelay <= 4'h0;
		wr(4'h4, 8'h00);
		wr(4'h8, 8'h01);
		pulse(6'h20);
		serve(16'h8004);
		wr(4'hC, 8'h82);
		pulse(6'h22);
		serve(16'h8004);
		wr(4'hC, 8'h82);
		serve(16'h000E);
	endtask : t_nmi
	// Reset for three cycles, then the scenarios.
	initial
	begin
		arst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0;
		events = 6'h00;
		extPin = 1'b0;
		keyPins = 4'hF;
		ackDelay = 4'h3;
		nTests = 0;
		miscompares = 0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		t_reset();
		t_order();
		t_pin();
		t_key();
		t_nmi();
		conclude(1'b0);
	end
endmodule : vic_controller_test
